// ==== shared/motion_report_defines.svh ====
// constants of the motion report register block
// assumes the core clock runs at 200 MHz and the host clocks the two-wire port
// Behaviour
// - read-only byte holds design revision code
// - status at 0x02, reset zero, top bit pending
// - bit 5 flags an LED drive fault
// - LED fault sticky until status is read
// - LED driven normally once fault disappears
// - bit 4 Y overflow, bit 3 X overflow
// - bit 0 shows active resolution 400/800
// - status read freezes X and Y displacement
// - repeated status read replaces held displacement
// - wide accumulators, overflow sets flag, motion lost
// - overflow clears after readout below full scale
// - excess motion saturates capture, pending stays set
// - X displacement at 0x03, signed, clear on read
// - Y displacement at 0x04, signed, clear on read
// - surface feature count at 0x05, unsigned byte
// - registers reached only through two-wire port
`ifndef MOTION_REPORT_DEFINES_SVH
`define MOTION_REPORT_DEFINES_SVH

`define REG_REVISION      7'h01
`define REG_STATUS        7'h02
`define REG_X_DISP        7'h03
`define REG_Y_DISP        7'h04
`define REG_SURFACE       7'h05

`define STATUS_RESET      8'h00
`define DISP_RESET        8'h00
`define SURFACE_RESET     8'h00
`define UNMAPPED_VALUE    8'h00

`define PENDING_BIT       7
`define LED_FAULT_BIT     5
`define Y_OVF_BIT         4
`define X_OVF_BIT         3
`define CPI_BIT           0

`define DIR_BIT           7
`define ACC_WIDTH         12
`define SUM_MAX           13'sh07FF
`define SUM_MIN           13'sh1800
`define ACC_MAX           12'sh7FF
`define ACC_MIN           12'sh800
`define DISP_MAX          8'sh7F
`define DISP_MIN          8'sh80
`define SYNC_WIDTH        3

`define CLOCK_PERIOD_NS   5
`define PORT_IDLE_NS      4000
`define PORT_IDLE_CYCLES  ((`PORT_IDLE_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`define IDLE_WIDTH        10

`endif

// ==== shared/motion_report_pkg.sv ====
// types shared by the motion report block
// assumes the defines header sits on the include path
`include "motion_report_defines.svh"

package motion_report_pkg;

    typedef enum logic [1:0] {
        PORT_ADDR  = 2'b00,
        PORT_READ  = 2'b01,
        PORT_WRITE = 2'b10
    } port_state_type;

    typedef struct packed {
        logic signed [`ACC_WIDTH-1:0] acc;
        logic signed [7:0]            held;
        logic                         overflow;
        logic                         drained;
    } axis_state_type;

    typedef struct packed {
        logic [`SYNC_WIDTH-1:0] first;
        logic [`SYNC_WIDTH-1:0] second;
    } sync_state_type;

    typedef struct packed {
        port_state_type          port;
        logic [2:0]              bit_count;
        logic [7:0]              shift;
        logic                    sclk_prev;
        logic                    sdio_out;
        logic                    sdio_oe;
        logic [`IDLE_WIDTH-1:0]  idle_count;
        logic                    led_fault;
        logic [7:0]              surface;
    } report_state_type;

endpackage

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser for the port clock, port data and LED fault pins
// assumes the inputs are asynchronous to clock
`timescale 1ns/10ps
`include "motion_report_defines.svh"

module pin_sync
    import motion_report_pkg::*;
(
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // pins
    input  wire logic [`SYNC_WIDTH-1:0] raw,
    output logic      [`SYNC_WIDTH-1:0] synced
);

    sync_state_type q;
    sync_state_type d;

    always_comb begin
        d        = q;
        d.first  = raw;
        d.second = q.first;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign synced = q.second;

endmodule

// ==== verilog/axis_accumulator.sv ====
// one motion axis: wide accumulator, frozen displacement byte, overflow flag
// assumes capture and read_out are one-cycle pulses and never coincide
`timescale 1ns/10ps
`include "motion_report_defines.svh"

module axis_accumulator
    import motion_report_pkg::*;
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // motion from the navigation core
    input  wire logic              motion_valid,
    input  wire logic signed [7:0] motion_delta,
    // register side effects
    input  wire logic              capture,
    input  wire logic              read_out,
    // results
    output logic signed [7:0]      held_value,
    output logic                   overflow,
    output logic                   pending
);

    axis_state_type q;
    axis_state_type d;

    logic signed [`ACC_WIDTH:0]   sum;
    logic signed [`ACC_WIDTH-1:0] acc_in;
    logic signed [7:0]            take;
    logic                         ovf_event;

    always_comb begin
        d         = q;
        sum       = {q.acc[`ACC_WIDTH-1], q.acc};
        ovf_event = 1'b0;
        if (motion_valid) begin
            sum = sum + {{(`ACC_WIDTH-7){motion_delta[7]}}, motion_delta};
        end
        // clamp rather than wrap, so the direction survives an overflow
        if (sum > `SUM_MAX) begin
            acc_in    = `ACC_MAX;
            ovf_event = 1'b1;
        end else if (sum < `SUM_MIN) begin
            acc_in    = `ACC_MIN;
            ovf_event = 1'b1;
        end else begin
            acc_in = sum[`ACC_WIDTH-1:0];
        end
        if (acc_in > $signed({{(`ACC_WIDTH-8){1'b0}}, `DISP_MAX})) begin
            take = `DISP_MAX;
        end else if (acc_in < $signed({{(`ACC_WIDTH-8){1'b1}}, `DISP_MIN})) begin
            take = `DISP_MIN;
        end else begin
            take = acc_in[7:0];
        end
        d.acc = acc_in;
        if (capture) begin
            // unread held bytes are dropped here by design
            d.held = take;
            d.acc  = acc_in - {{(`ACC_WIDTH-8){take[7]}}, take};
        end else if (read_out) begin
            d.held    = `DISP_RESET;
            d.drained = 1'b1;
        end
        if (ovf_event) begin
            d.overflow = 1'b1;
            d.drained  = 1'b0;
        end else if (q.drained && acc_in != `ACC_MAX && acc_in != `ACC_MIN) begin
            d.overflow = 1'b0;
            d.drained  = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign held_value = q.held;
    assign overflow   = q.overflow;
    assign pending    = (q.acc != '0) || (q.held != '0);

endmodule

// ==== verilog/motion_report_registers.sv ====
// motion report registers behind the two-wire serial port
// assumes the host clocks the port slowly against the 200 MHz core clock
// assumes motion and frame inputs come from logic on the core clock
`timescale 1ns/10ps
`include "motion_report_defines.svh"

module motion_report_registers
    import motion_report_pkg::*;
#(
    // arbitrary value, no real part implied
    parameter logic [7:0] DESIGN_REVISION = 8'h5A
)
(
    // clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // two-wire serial port
    input  wire logic              sclk,
    input  wire logic              sdio_in,
    output logic                   sdio_out,
    output logic                   sdio_oe,
    // motion from the navigation core
    input  wire logic              motion_valid,
    input  wire logic signed [7:0] delta_x,
    input  wire logic signed [7:0] delta_y,
    input  wire logic              cpi_select_bit,
    // frame results
    input  wire logic              frame_done,
    input  wire logic [7:0]        frame_feature_count,
    // LED supervision
    input  wire logic              led_fault_raw,
    output logic                   led_drive_enable,
    // status
    output logic                   movement_pending
);

    report_state_type q;
    report_state_type d;

    // synchronised pins
    logic [`SYNC_WIDTH-1:0] pins_raw;
    logic [`SYNC_WIDTH-1:0] pins_sync;
    logic                   sclk_s;
    logic                   sdio_s;
    logic                   led_fault_s;

    // port edges
    logic                   sclk_rise;
    logic                   sclk_fall;

    // per-axis signals, index 0 is X and 1 is Y
    logic                   axis_valid;
    logic signed [7:0]      axis_delta   [2];
    logic                   axis_capture;
    logic [1:0]             axis_read;
    logic signed [7:0]      axis_held    [2];
    logic [1:0]             axis_ovf;
    logic [1:0]             axis_pending;

    // read decode
    logic [7:0]             addr_byte;
    logic [6:0]             reg_addr;
    logic [7:0]             read_data;
    logic [7:0]             status_byte;
    logic                   status_read;
    logic                   x_read;
    logic                   y_read;

    assign pins_raw = {led_fault_raw, sdio_in, sclk};

    pin_sync u_pin_sync (
        .clock  (clock),
        .rst_n  (rst_n),
        .raw    (pins_raw),
        .synced (pins_sync)
    );

    assign sclk_s      = pins_sync[0];
    assign sdio_s      = pins_sync[1];
    assign led_fault_s = pins_sync[2];

    assign sclk_rise = sclk_s && !q.sclk_prev;
    assign sclk_fall = !sclk_s && q.sclk_prev;

    assign axis_valid    = motion_valid;
    assign axis_delta[0] = delta_x;
    assign axis_delta[1] = delta_y;
    assign axis_read     = {y_read, x_read};
    assign axis_capture  = status_read;

    // deltas already arrive at the active resolution
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_axis
            axis_accumulator u_axis (
                .clock        (clock),
                .rst_n        (rst_n),
                .motion_valid (axis_valid),
                .motion_delta (axis_delta[ch]),
                .capture      (axis_capture),
                .read_out     (axis_read[ch]),
                .held_value   (axis_held[ch]),
                .overflow     (axis_ovf[ch]),
                .pending      (axis_pending[ch])
            );
        end
    endgenerate

    // status byte as seen at the moment of the read
    always_comb begin
        status_byte                 = `STATUS_RESET;
        status_byte[`PENDING_BIT]   = |axis_pending;
        // a fault present in the read cycle is reported, not lost
        status_byte[`LED_FAULT_BIT] = q.led_fault || led_fault_s;
        status_byte[`Y_OVF_BIT]     = axis_ovf[1];
        status_byte[`X_OVF_BIT]     = axis_ovf[0];
        status_byte[`CPI_BIT]       = cpi_select_bit;
    end

    // address byte completes on the eighth rising port clock
    assign addr_byte = {q.shift[6:0], sdio_s};
    assign reg_addr  = addr_byte[6:0];

    // register access only through the serial port
    always_comb begin
        read_data   = `UNMAPPED_VALUE;
        status_read = 1'b0;
        x_read      = 1'b0;
        y_read      = 1'b0;
        if (q.port == PORT_ADDR && sclk_rise && q.bit_count == 3'h7
            && !addr_byte[`DIR_BIT]) begin
            if (reg_addr == `REG_REVISION) begin
                read_data = DESIGN_REVISION;
            end else if (reg_addr == `REG_STATUS) begin
                read_data   = status_byte;
                status_read = 1'b1;
            end else if (reg_addr == `REG_X_DISP) begin
                read_data = axis_held[0];
                x_read    = 1'b1;
            end else if (reg_addr == `REG_Y_DISP) begin
                read_data = axis_held[1];
                y_read    = 1'b1;
            end else if (reg_addr == `REG_SURFACE) begin
                read_data = q.surface;
            end else begin
                read_data = `UNMAPPED_VALUE;
            end
        end
    end

    // port sequencing and the block's own flags
    always_comb begin
        d           = q;
        d.sclk_prev = sclk_s;

        // no edge for a long time puts the port back to the address phase
        if (sclk_rise || sclk_fall) begin
            d.idle_count = '0;
        end else if (q.idle_count != `IDLE_WIDTH'(`PORT_IDLE_CYCLES)) begin
            d.idle_count = q.idle_count + `IDLE_WIDTH'(1);
        end

        case (q.port)
            PORT_ADDR: begin
                if (sclk_rise) begin
                    d.shift     = addr_byte;
                    d.bit_count = q.bit_count + 3'h1;
                    if (q.bit_count == 3'h7) begin
                        d.bit_count = 3'h0;
                        if (addr_byte[`DIR_BIT]) begin
                            d.port = PORT_WRITE;
                        end else begin
                            d.shift = read_data;
                            d.port  = PORT_READ;
                        end
                    end
                end
            end
            PORT_READ: begin
                // drive on falling edges so data is stable at the host's rise
                if (sclk_fall) begin
                    d.sdio_oe  = 1'b1;
                    d.sdio_out = q.shift[7];
                    d.shift    = {q.shift[6:0], 1'b0};
                end
                if (sclk_rise) begin
                    d.bit_count = q.bit_count + 3'h1;
                    if (q.bit_count == 3'h7) begin
                        d.bit_count = 3'h0;
                        d.sdio_oe   = 1'b0;
                        d.sdio_out  = 1'b0;
                        d.port      = PORT_ADDR;
                    end
                end
            end
            PORT_WRITE: begin
                // none of these registers is writable, data is dropped
                if (sclk_rise) begin
                    d.shift     = {q.shift[6:0], sdio_s};
                    d.bit_count = q.bit_count + 3'h1;
                    if (q.bit_count == 3'h7) begin
                        d.bit_count = 3'h0;
                        d.port      = PORT_ADDR;
                    end
                end
            end
            default: begin
                d.port      = PORT_ADDR;
                d.bit_count = 3'h0;
                d.sdio_oe   = 1'b0;
                d.sdio_out  = 1'b0;
            end
        endcase

        if (q.idle_count == `IDLE_WIDTH'(`PORT_IDLE_CYCLES)
            && (q.port != PORT_ADDR || q.bit_count != 3'h0)) begin
            d.port      = PORT_ADDR;
            d.bit_count = 3'h0;
            d.sdio_oe   = 1'b0;
            d.sdio_out  = 1'b0;
        end

        // sticky fault: a fault in the clearing cycle wins over the clear
        if (led_fault_s) begin
            d.led_fault = 1'b1;
        end else if (status_read) begin
            d.led_fault = 1'b0;
        end

        if (frame_done) begin
            d.surface = frame_feature_count;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q            <= '0;
            q.port       <= PORT_ADDR;
            q.surface    <= `SURFACE_RESET;
        end else begin
            q <= d;
        end
    end

    assign sdio_out         = q.sdio_out;
    assign sdio_oe          = q.sdio_oe;
    // the drive returns by itself once the pin reports no fault
    assign led_drive_enable = !led_fault_s;
    assign movement_pending = |axis_pending;

endmodule

// ==== verification/motion_report_chk.sv ====
// port assertions for the motion report registers
// bound to the top module; one core clock domain
`timescale 1ns/10ps

module motion_report_chk (
    // clock and reset
    input wire logic              clock,
    input wire logic              rst_n,
    // port and core signals
    input wire logic              sclk,
    input wire logic              sdio_out,
    input wire logic              sdio_oe,
    input wire logic              motion_valid,
    input wire logic signed [7:0] delta_x,
    input wire logic              led_fault_raw,
    input wire logic              led_drive_enable,
    input wire logic              movement_pending
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_quiet;
        !sdio_oe |-> !sdio_out;
    endproperty
    a_quiet: assert property (p_quiet) else $error("data high while released");
    property p_on_low;
        $rose(sdio_oe) |-> !sclk;
    endproperty
    a_on_low: assert property (p_on_low) else $error("drive began off a low clock");
    property p_off_high;
        $fell(sdio_oe) |-> sclk;
    endproperty
    a_off_high: assert property (p_off_high) else $error("drive ended off a high clock");
    // port outputs only move on a port clock edge; an idle timeout release of a read also fails this check
    property p_still;
        $stable(sclk) [*8] |=> $stable(sdio_oe) && $stable(sdio_out);
    endproperty
    a_still: assert property (p_still) else $error("port output moved without clock");
    property p_mot_set;
        motion_valid && delta_x != 8'sh00 |=> movement_pending;
    endproperty
    a_mot_set: assert property (p_mot_set) else $error("motion not pending");
    property p_mot_rise;
        $rose(movement_pending) |-> $past(motion_valid);
    endproperty
    a_mot_rise: assert property (p_mot_rise) else $error("pending without motion");
    // drain happens in a status or displacement read, which then answers; motion that cancels the count to zero also drains and fails this check
    property p_mot_fall;
        $fell(movement_pending) |-> !$past(motion_valid) ##[1:40] sdio_oe;
    endproperty
    a_mot_fall: assert property (p_mot_fall) else $error("pending cleared oddly");
    property p_led_off;
        led_fault_raw [*5] |-> !led_drive_enable;
    endproperty
    a_led_off: assert property (p_led_off) else $error("led driven during fault");
    property p_led_on;
        !led_fault_raw [*5] |-> led_drive_enable;
    endproperty
    a_led_on: assert property (p_led_on) else $error("led not resumed");

    c_answer: cover property ($rose(sdio_oe));
    c_drained: cover property ($fell(movement_pending));
    c_fault: cover property ($fell(led_drive_enable));
endmodule

bind motion_report_registers motion_report_chk u_motion_report_chk (
    .clock(clock), .rst_n(rst_n), .sclk(sclk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .motion_valid(motion_valid), .delta_x(delta_x), .led_fault_raw(led_fault_raw),
    .led_drive_enable(led_drive_enable), .movement_pending(movement_pending));

// ==== verification/host_model.sv ====
// host controller on the two-wire port, 160 ns port clock
// clock idles low; released data line shows the inverse of the last bit
`timescale 1ns/10ps

module host_model (
    // two-wire port
    output logic      sclk,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    logic host_bit;
    logic host_on;

    assign sdio_in = sdio_oe ? sdio_out : (host_on ? host_bit : ~host_bit);

    initial begin
        sclk = 1'b0;
        host_bit = 1'b0;
        host_on = 1'b1;
    end

    // address byte then data byte, msb first; bit 7 of addr marks a write
    task automatic xfer(input logic [7:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        integer i;
        rdata = 8'h00;
        for (i = 15; i >= 0; i--) begin
            sclk = 1'b0;
            if (i >= 8)
                host_bit = addr[i-8];
            else if (addr[7])
                host_bit = wdata[i];
            else
                host_on = 1'b0;
            #80;
            sclk = 1'b1;
            if (i < 8)
                rdata[i] = sdio_in;
            #80;
        end
        sclk = 1'b0;
        host_on = 1'b1;
        #400;
    endtask
endmodule

// ==== verification/motion_report_registers_bench.sv ====
// self-checking bench for the motion report registers
// host model drives the port; core inputs change on falling edges
`timescale 1ns/10ps

module motion_report_registers_bench;
    localparam logic [7:0] REV = 8'hC3; // arbitrary revision value

    logic              clock, rst_n, sclk, sdio_in, sdio_out, sdio_oe, motion_valid;
    logic              cpi_select_bit, frame_done, led_fault_raw, led_drive_enable;
    logic              movement_pending;
    logic signed [7:0] delta_x, delta_y;
    logic [7:0]        frame_feature_count, v, vx, vy;
    logic [15:0]       sum_x, sum_y, rounds;
    int                mismatches, comparisons;

    motion_report_registers #(.DESIGN_REVISION(REV)) u_motion_report_registers (
        .clock(clock), .rst_n(rst_n), .sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .motion_valid(motion_valid), .delta_x(delta_x),
        .delta_y(delta_y), .cpi_select_bit(cpi_select_bit), .frame_done(frame_done),
        .frame_feature_count(frame_feature_count), .led_fault_raw(led_fault_raw),
        .led_drive_enable(led_drive_enable), .movement_pending(movement_pending));
    host_model u_host_model (.sclk(sclk), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task rd(input logic [7:0] addr, input logic [7:0] exp);
        u_host_model.xfer(addr, 8'h00, v);
        check({8'h00, v}, {8'h00, exp});
    endtask

    task move(input logic signed [7:0] dx, input logic signed [7:0] dy);
        @(negedge clock);
        delta_x = dx;
        delta_y = dy;
        motion_valid = 1'b1;
        @(negedge clock);
        motion_valid = 1'b0;
    endtask

    task frame(input logic [7:0] count);
        @(negedge clock);
        frame_feature_count = count;
        frame_done = 1'b1;
        @(negedge clock);
        frame_done = 1'b0;
    endtask

    // whole run is near 45k cycles; limit kept well under 100k cycles
    initial begin
        #400000;
        mismatches++;
        test_done();
    end

    initial begin
        mismatches = 0;
        comparisons = 0;
        rst_n = 1'b0;
        motion_valid = 1'b0;
        delta_x = 8'sh00;
        delta_y = 8'sh00;
        cpi_select_bit = 1'b0;
        frame_done = 1'b0;
        frame_feature_count = 8'h00;
        led_fault_raw = 1'b0;
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (5) @(negedge clock);
        rd(8'h01, REV);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h00);
        rd(8'h05, 8'h00);
        rd(8'h07, 8'h00);
        @(negedge clock);
        cpi_select_bit = 1'b1;
        rd(8'h02, 8'h01);
        @(negedge clock);
        cpi_select_bit = 1'b0;
        rd(8'h02, 8'h00);
        move(8'sh05, -8'sh03);
        check({15'h0000, movement_pending}, 16'h0001);
        rd(8'h02, 8'h80);
        move(8'sh02, 8'sh00);
        rd(8'h03, 8'h05);
        rd(8'h04, 8'hFD);
        rd(8'h03, 8'h00);
        rd(8'h02, 8'h80);
        move(8'sh04, 8'sh00);
        rd(8'h02, 8'h80);
        rd(8'h03, 8'h04);
        rd(8'h04, 8'h00);
        rd(8'h02, 8'h00);
        // overfill both axes past the accumulator range
        repeat (17) move(8'sh7F, 8'sh80);
        rounds = 16'h0000;
        sum_x = 16'h0000;
        sum_y = 16'h0000;
        v = 8'h80;
        while (v[7] && rounds < 16'h0028) begin
            u_host_model.xfer(8'h02, 8'h00, v);
            if (v[7]) begin
                rounds = rounds + 16'h0001;
                if (rounds == 16'h0001) check({8'h00, v}, 16'h0098);
                if (rounds == 16'h0002) check({8'h00, v}, 16'h0080);
                u_host_model.xfer(8'h03, 8'h00, vx);
                u_host_model.xfer(8'h04, 8'h00, vy);
                if (rounds == 16'h0001) check({vx, vy}, 16'h7F80);
                sum_x = sum_x + {{8{vx[7]}}, vx};
                sum_y = sum_y + {{8{vy[7]}}, vy};
            end
        end
        check(rounds, 16'h0011);
        check({15'h0000, movement_pending}, 16'h0000);
        check(sum_x, 16'h07FF);
        check(sum_y, 16'hF800);
        @(negedge clock);
        led_fault_raw = 1'b1;
        repeat (10) @(negedge clock);
        check({15'h0000, led_drive_enable}, 16'h0000);
        led_fault_raw = 1'b0;
        repeat (10) @(negedge clock);
        check({15'h0000, led_drive_enable}, 16'h0001);
        rd(8'h02, 8'h20);
        rd(8'h02, 8'h00);
        frame(8'hFF);
        rd(8'h05, 8'hFF);
        u_host_model.xfer(8'h85, 8'h33, v);
        rd(8'h05, 8'hFF);
        frame(8'h00);
        rd(8'h05, 8'h00);
        test_done();
    end
endmodule
